// ===== cdt_pkg.sv
package cdt_pkg;

   localparam int unsigned CLK_PER_INST   = 4;
   localparam int unsigned TMR_DIV_SLOW   = 12;
   localparam int unsigned TMR_DIV_FAST   = 4;
   localparam int unsigned DIV_W          = 4;
   localparam int unsigned CYC_W          = 4;
   localparam int unsigned BYTE_W         = 2;
   localparam int unsigned STRETCH_W      = 3;
   localparam logic [2:0]  STRETCH_RST    = 3'h1;
   localparam logic [3:0]  XDATA_BASE_CYC = 4'h2;
   localparam logic [7:0]  CLK_CTRL_ADDR  = 8'h8E;

   typedef enum logic [5:0] {
      CDT_OTHER,
      CDT_NOP,
      CDT_LOAD_PTR_IMM,
      CDT_CODE_MOVE_PTR,
      CDT_CODE_MOVE_PC,
      CDT_XDATA_RD,
      CDT_XDATA_WR,
      CDT_PUSH,
      CDT_POP,
      CDT_EXCHANGE,
      CDT_NIBBLE_EXCH,
      CDT_CLR_C,
      CDT_SET_C,
      CDT_INV_C,
      CDT_CLR_BIT,
      CDT_SET_BIT,
      CDT_INV_BIT,
      CDT_AND_C,
      CDT_AND_C_INV,
      CDT_OR_C,
      CDT_OR_C_INV,
      CDT_MOV_C_BIT,
      CDT_MOV_BIT_C,
      CDT_CALL_ABS,
      CDT_JUMP_ABS,
      CDT_CALL_LONG,
      CDT_JUMP_LONG,
      CDT_JUMP_BIT_CLR,
      CDT_JMP_IND,
      CDT_JUMP_ZERO,
      CDT_JUMP_NONZERO,
      CDT_CMP_JUMP,
      CDT_DEC_JUMP
   } cdt_class_t;

endpackage

// ===== cdt_dec_if.sv
`timescale 1ns/100ps
interface cdt_dec_if;
   import cdt_pkg::*;
   logic [7:0]                      opcode;
   logic [cdt_pkg::STRETCH_W-1:0]   stretch;
   cdt_pkg::cdt_class_t             cls;
   logic [cdt_pkg::BYTE_W-1:0]      bytes;
   logic [cdt_pkg::CYC_W-1:0]       cycles;

   modport table_side (input opcode, input stretch, output cls, output bytes, output cycles);
   modport core_side  (output opcode, output stretch, input cls, input bytes, input cycles);
endinterface

// ===== cdt_pulse_div.sv
`timescale 1ns/100ps
module cdt_pulse_div #(
   parameter int unsigned W = 4
) (
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_restart,
   input  wire logic [W-1:0] i_ratio,
   output logic              o_tick
);
   logic [W-1:0] cnt;

   if (W < 2)
   begin : g_bad_width
      $error("cdt_pulse_div: W must be at least 2");
   end

   // Compare with >= so a ratio cut mid-count cannot overrun
   assign o_tick = (cnt >= i_ratio - W'(1));

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || i_restart)
         cnt <= '0;
      else if (o_tick)
         cnt <= '0;
      else
         cnt <= cnt + W'(1);
   end
endmodule

// ===== cdt_op_table.sv
`timescale 1ns/100ps
module cdt_op_table (
   cdt_dec_if.table_side dec
);
   import cdt_pkg::*;

   always_comb
   begin
      dec.cls    = CDT_OTHER;
      dec.bytes  = BYTE_W'(1);
      dec.cycles = CYC_W'(1);
      if (dec.opcode[4:0] == 5'h11)
      begin
         dec.cls = CDT_CALL_ABS;
         dec.bytes = 2'h2;
         dec.cycles = 4'h3;
      end
      else if (dec.opcode[4:0] == 5'h01)
      begin
         dec.cls = CDT_JUMP_ABS;
         dec.bytes = 2'h2;
         dec.cycles = 4'h3;
      end
      else if (dec.opcode[7:3] == 5'h19)
      begin
         dec.cls = CDT_EXCHANGE;
      end
      else if (dec.opcode[7:3] == 5'h17)
      begin
         dec.cls = CDT_CMP_JUMP;
         dec.bytes = 2'h3;
         dec.cycles = 4'h4;
      end
      else if (dec.opcode[7:3] == 5'h1B)
      begin
         dec.cls = CDT_DEC_JUMP;
         dec.bytes = 2'h2;
         dec.cycles = 4'h3;
      end
      else
      begin
         case (dec.opcode)
            8'h00, 8'hA5: dec.cls = CDT_NOP;
            8'h90:
            begin
               dec.cls = CDT_LOAD_PTR_IMM;
               dec.bytes = 2'h3;
               dec.cycles = 4'h3;
            end
            8'h93, 8'h83:
            begin
               dec.cls = dec.opcode[4] ? CDT_CODE_MOVE_PTR : CDT_CODE_MOVE_PC;
               dec.cycles = 4'h3;
            end
            8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3:
            begin
               dec.cls = dec.opcode[4] ? CDT_XDATA_WR : CDT_XDATA_RD;
               // Base two plus the stretch setting
               dec.cycles = XDATA_BASE_CYC + CYC_W'(dec.stretch);
            end
            8'hC0, 8'hD0:
            begin
               dec.cls = dec.opcode[4] ? CDT_POP : CDT_PUSH;
               dec.bytes = 2'h2;
               dec.cycles = 4'h2;
            end
            8'hC5:
            begin
               dec.cls = CDT_EXCHANGE;
               dec.bytes = 2'h2;
               dec.cycles = 4'h2;
            end
            8'hC6, 8'hC7: dec.cls = CDT_EXCHANGE;
            8'hD6, 8'hD7: dec.cls = CDT_NIBBLE_EXCH;
            8'hC3: dec.cls = CDT_CLR_C;
            8'hD3: dec.cls = CDT_SET_C;
            8'hB3: dec.cls = CDT_INV_C;
            8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92:
            begin
               dec.bytes = 2'h2;
               dec.cycles = 4'h2;
               case (dec.opcode)
                  8'hC2: dec.cls = CDT_CLR_BIT;
                  8'hD2: dec.cls = CDT_SET_BIT;
                  8'hB2: dec.cls = CDT_INV_BIT;
                  8'h82: dec.cls = CDT_AND_C;
                  8'hB0: dec.cls = CDT_AND_C_INV;
                  8'h72: dec.cls = CDT_OR_C;
                  8'hA0: dec.cls = CDT_OR_C_INV;
                  8'hA2: dec.cls = CDT_MOV_C_BIT;
                  default: dec.cls = CDT_MOV_BIT_C;
               endcase
            end
            8'h12, 8'h02:
            begin
               dec.cls = dec.opcode[4] ? CDT_CALL_LONG : CDT_JUMP_LONG;
               dec.bytes = 2'h3;
               dec.cycles = 4'h4;
            end
            8'h10:
            begin
               dec.cls = CDT_JUMP_BIT_CLR;
               dec.bytes = 2'h3;
               dec.cycles = 4'h4;
            end
            8'h73:
            begin
               dec.cls = CDT_JMP_IND;
               dec.cycles = 4'h3;
            end
            8'h60, 8'h70:
            begin
               dec.cls = dec.opcode[4] ? CDT_JUMP_NONZERO : CDT_JUMP_ZERO;
               dec.bytes = 2'h2;
               dec.cycles = 4'h3;
            end
            8'hB4, 8'hB5, 8'hB6, 8'hB7:
            begin
               dec.cls = CDT_CMP_JUMP;
               dec.bytes = 2'h3;
               dec.cycles = 4'h4;
            end
            8'hD5:
            begin
               dec.cls = CDT_DEC_JUMP;
               dec.bytes = 2'h3;
               dec.cycles = 4'h4;
            end
            default: dec.cls = CDT_OTHER;
         endcase
      end
   end
endmodule

// ===== cdt_decode.sv
`timescale 1ns/100ps
// Contract
// - Opcode 90 loads 16-bit immediate into data_pointer; three bytes, three cycles.
// - Opcodes 93 and 83 fetch code byte at base plus accumulator; three cycles.
// - E0, E2-E3 read external data into accumulator; one byte, two to nine cycles.
// - F0, F2-F3 write accumulator to external data; one byte, two to nine cycles.
// - C0 pushes, D0 pops a direct byte; push is two bytes, two cycles.
// - C8-CF, C5, C6-C7 swap accumulator with register, direct or indirect byte.
// - D6-D7 swap low nibbles with indirect memory; one byte, one cycle.
// - C3 clears carry, D3 sets it, B3 inverts it; one cycle each.
// - C2, D2, B2 clear, set, invert a direct bit; carry untouched.
// - 82 and B0 AND carry with bit or its inverse; two cycles.
// - 72 and A0 OR carry with bit or its inverse; two cycles.
// - A2 copies bit to carry, 92 copies carry to bit.
// - Eleven-bit call and jump families: two bytes, three cycles.
// - Long call 12 and long jump 02: three bytes, four cycles.
// - Opcode 10 branches when bit is one and clears that bit.
// - Opcode 73 jumps to data_pointer plus accumulator in three cycles.
// - 60 branches on zero accumulator, 70 on non-zero; three cycles.
// - Compare-jump forms branch on inequality, update carry; four cycles.
// - Decrement-jump forms branch on non-zero result; register or direct.
// - Opcodes 00 and A5 do nothing in one byte, one cycle.
// - One instruction cycle spans exactly four clocks.
// - Timers tick every twelve clocks by default, or every four.
// - External move takes two cycles plus three-bit stretch_field.
// - stretch_field resets to one, giving three-cycle external moves.
module cdt_decode (
   input  wire logic                         i_clk,
   input  wire logic                         i_sys_rst,
   input  wire logic                         i_op_valid,
   input  wire logic [7:0]                   i_opcode,
   input  wire logic                         i_acc_zero,
   input  wire logic                         i_bit_val,
   input  wire logic                         i_cmp_ne,
   input  wire logic                         i_cmp_lt,
   input  wire logic                         i_dec_nz,
   input  wire logic                         i_carry_wr,
   input  wire logic                         i_carry_in,
   input  wire logic                         i_clk_ctrl_wr,
   input  wire logic [7:0]                   i_clk_ctrl_wdata,
   input  wire logic                         i_timer_fast,
   output logic                              o_op_ready,
   output cdt_pkg::cdt_class_t               o_class,
   output logic [cdt_pkg::BYTE_W-1:0]        o_bytes,
   output logic [cdt_pkg::CYC_W-1:0]         o_cycles,
   output logic                              o_done,
   output logic                              o_branch,
   output logic                              o_bit_wr,
   output logic                              o_bit_data,
   output logic                              o_carry_flag,
   output logic [cdt_pkg::STRETCH_W-1:0]     o_stretch,
   output logic                              o_inst_tick,
   output logic                              o_timer_tick
);
   import cdt_pkg::*;

   typedef enum logic {CDT_IDLE, CDT_EXEC} cdt_state_t;

   cdt_state_t          state;
   logic [CYC_W-1:0]    remain;
   logic                take;
   logic                bit_q;
   logic                taken_q;
   logic                last_tick;
   logic                next_carry;
   logic                next_taken;
   logic [DIV_W-1:0]    tmr_ratio;

   cdt_dec_if dec ();

   assign dec.opcode  = i_opcode;
   assign dec.stretch = o_stretch;
   assign o_op_ready  = (state == CDT_IDLE);
   assign take        = i_op_valid && o_op_ready;
   assign last_tick   = (state == CDT_EXEC) && o_inst_tick && (remain == CYC_W'(1));

   cdt_op_table u_table (
      .dec (dec)
   );

   // Restarted on each accepted opcode so cycle counts align to it
   cdt_pulse_div #(.W(DIV_W)) u_inst_div (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_restart (take),
      .i_ratio   (DIV_W'(CLK_PER_INST)),
      .o_tick    (o_inst_tick)
   );

   assign tmr_ratio = i_timer_fast ? DIV_W'(TMR_DIV_FAST) : DIV_W'(TMR_DIV_SLOW);

   cdt_pulse_div #(.W(DIV_W)) u_tmr_div (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_restart (1'b0),
      .i_ratio   (tmr_ratio),
      .o_tick    (o_timer_tick)
   );

   // Stretch is sampled at accept; a later write affects the next move
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_stretch <= STRETCH_RST;
      else if (i_clk_ctrl_wr)
         o_stretch <= i_clk_ctrl_wdata[STRETCH_W-1:0];
   end

   always_comb
   begin
      case (o_class)
         CDT_CALL_ABS, CDT_JUMP_ABS, CDT_CALL_LONG, CDT_JUMP_LONG, CDT_JMP_IND:
            next_taken = 1'b1;
         CDT_JUMP_BIT_CLR: next_taken = i_bit_val;
         CDT_JUMP_ZERO:    next_taken = i_acc_zero;
         CDT_JUMP_NONZERO: next_taken = !i_acc_zero;
         CDT_CMP_JUMP:     next_taken = i_cmp_ne;
         CDT_DEC_JUMP:     next_taken = i_dec_nz;
         default:  next_taken = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         state    <= CDT_IDLE;
         remain   <= '0;
         o_class  <= CDT_NOP;
         o_bytes  <= '0;
         o_cycles <= '0;
      end
      else if (take)
      begin
         state    <= CDT_EXEC;
         remain   <= dec.cycles;
         o_class  <= dec.cls;
         o_bytes  <= dec.bytes;
         o_cycles <= dec.cycles;
      end
      else if ((state == CDT_EXEC) && o_inst_tick)
      begin
         remain <= remain - CYC_W'(1);
         if (remain == CYC_W'(1))
            state <= CDT_IDLE;
      end
   end

   // Operand conditions are held from the first cycle after accept
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         bit_q   <= 1'b0;
         taken_q <= 1'b0;
      end
      else if ((state == CDT_EXEC) && (remain == o_cycles) && !o_inst_tick)
      begin
         bit_q   <= i_bit_val;
         taken_q <= next_taken;
      end
   end

   always_comb
   begin
      case (o_class)
         CDT_CLR_C:     next_carry = 1'b0;
         CDT_SET_C:     next_carry = 1'b1;
         CDT_INV_C:     next_carry = !o_carry_flag;
         CDT_AND_C:     next_carry = o_carry_flag & bit_q;
         CDT_AND_C_INV: next_carry = o_carry_flag & !bit_q;
         CDT_OR_C:      next_carry = o_carry_flag | bit_q;
         CDT_OR_C_INV:  next_carry = o_carry_flag | !bit_q;
         CDT_MOV_C_BIT: next_carry = bit_q;
         CDT_CMP_JUMP:  next_carry = i_cmp_lt;
         default:       next_carry = o_carry_flag;
      endcase
   end

   // Own instruction wins over a datapath carry write in the same cycle
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_carry_flag <= 1'b0;
      else if (last_tick)
         o_carry_flag <= next_carry;
      else if (i_carry_wr)
         o_carry_flag <= i_carry_in;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_done     <= 1'b0;
         o_branch   <= 1'b0;
         o_bit_wr   <= 1'b0;
         o_bit_data <= 1'b0;
      end
      else
      begin
         o_done   <= last_tick;
         o_branch <= last_tick && taken_q;
         o_bit_wr <= 1'b0;
         if (last_tick)
         begin
            case (o_class)
               CDT_CLR_BIT:
               begin
                  o_bit_wr   <= 1'b1;
                  o_bit_data <= 1'b0;
               end
               CDT_SET_BIT:
               begin
                  o_bit_wr   <= 1'b1;
                  o_bit_data <= 1'b1;
               end
               CDT_INV_BIT:
               begin
                  o_bit_wr   <= 1'b1;
                  o_bit_data <= !bit_q;
               end
               CDT_MOV_BIT_C:
               begin
                  o_bit_wr   <= 1'b1;
                  o_bit_data <= o_carry_flag;
               end
               CDT_JUMP_BIT_CLR:
               begin
                  o_bit_wr   <= taken_q;
                  o_bit_data <= 1'b0;
               end
               default: o_bit_data <= o_bit_data;
            endcase
         end
      end
   end

   // Checking helpers
   logic [5:0]       elapsed;
   logic [DIV_W-1:0] tmr_gap;
   logic             rate_same;
   logic             fast_q;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         elapsed   <= '0;
         tmr_gap   <= '0;
         rate_same <= 1'b0;
         fast_q    <= 1'b0;
      end
      else
      begin
         fast_q <= i_timer_fast;
         if (take)
            elapsed <= '0;
         else if (state == CDT_EXEC)
            elapsed <= elapsed + 6'h01;
         tmr_gap   <= o_timer_tick ? DIV_W'(1) : tmr_gap + DIV_W'(1);
         rate_same <= o_timer_tick ? 1'b1 : (rate_same && (i_timer_fast == fast_q));
      end
   end

   property p_done_timing;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_done |-> (elapsed == 6'(CLK_PER_INST) * {2'b00, o_cycles});
   endproperty
   a_done_timing: assert property (p_done_timing) else $error("done not 4 clocks per cycle");

   property p_stretch_rst;
      @(posedge i_clk) i_sys_rst |=> (o_stretch == STRETCH_RST);
   endproperty
   a_stretch_rst: assert property (p_stretch_rst) else $error("stretch not one after reset");

   property p_xdata_cyc;
      @(posedge i_clk) disable iff (i_sys_rst)
      (take && (i_opcode == 8'hE0)) |=> (o_cycles == XDATA_BASE_CYC + CYC_W'($past(o_stretch)));
   endproperty
   a_xdata_cyc: assert property (p_xdata_cyc) else $error("external move cycles wrong");

   property p_nop;
      @(posedge i_clk) disable iff (i_sys_rst)
      (take && (i_opcode == 8'hA5)) |=> (o_class == CDT_NOP) && (o_cycles == 4'h1) ##4 o_done;
   endproperty
   a_nop: assert property (p_nop) else $error("reserved opcode not a one-cycle nop");

   property p_ptr_imm;
      @(posedge i_clk) disable iff (i_sys_rst)
      (take && (i_opcode == 8'h90)) |=> (o_bytes == 2'h3) && (o_cycles == 4'h3);
   endproperty
   a_ptr_imm: assert property (p_ptr_imm) else $error("data_pointer load size wrong");

   property p_clr_c;
      @(posedge i_clk) disable iff (i_sys_rst)
      (last_tick && (o_class == CDT_CLR_C)) |=> !o_carry_flag;
   endproperty
   a_clr_c: assert property (p_clr_c) else $error("carry not cleared");

   property p_bit_keeps_carry;
      @(posedge i_clk) disable iff (i_sys_rst)
      (last_tick && (o_class inside {CDT_CLR_BIT, CDT_SET_BIT, CDT_INV_BIT}))
      |=> $stable(o_carry_flag) && o_bit_wr;
   endproperty
   a_bit_keeps_carry: assert property (p_bit_keeps_carry) else $error("bit op moved carry");

   property p_and_c;
      @(posedge i_clk) disable iff (i_sys_rst)
      (last_tick && (o_class == CDT_AND_C))
      |=> (o_carry_flag == ($past(o_carry_flag) & $past(bit_q)));
   endproperty
   a_and_c: assert property (p_and_c) else $error("carry AND bit wrong");

   property p_bit_jump_clear;
      @(posedge i_clk) disable iff (i_sys_rst)
      (o_done && o_branch && (o_class == CDT_JUMP_BIT_CLR)) |-> (o_bit_wr && !o_bit_data);
   endproperty
   a_bit_jump_clear: assert property (p_bit_jump_clear) else $error("bit jump did not clear");

   property p_timer_gap;
      @(posedge i_clk) disable iff (i_sys_rst)
      (o_timer_tick && rate_same && (i_timer_fast == fast_q))
      |-> (tmr_gap == (i_timer_fast ? DIV_W'(TMR_DIV_FAST) : DIV_W'(TMR_DIV_SLOW)));
   endproperty
   a_timer_gap: assert property (p_timer_gap) else $error("timer tick spacing wrong");

   c_long_move: cover property (@(posedge i_clk) o_done && (o_class == CDT_XDATA_RD) && (o_cycles == 4'h9));
   c_bit_jump_taken: cover property (@(posedge i_clk) o_done && o_branch && (o_class == CDT_JUMP_BIT_CLR));
   c_fast_timer: cover property (@(posedge i_clk) o_timer_tick && i_timer_fast && rate_same);
endmodule

// ===== cdt_decode_spare.sv
`timescale 1ns/100ps

// ===== cdt_fetch_model.sv
`timescale 1ns/100ps
module cdt_fetch_model (
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_op_ready,
   output logic            o_op_valid,
   output logic [7:0]      o_opcode,
   output logic [4:0]      o_operands
);
   logic [12:0] q [$];
   logic [4:0]  pend;
   task automatic push(input logic [7:0] op, input logic [4:0] opnd);
      q.push_back({op, opnd});
   endtask
   initial
   begin
      o_op_valid = 1'b0;
      o_opcode   = 8'h00;
      o_operands = 5'h00;
      pend       = 5'h00;
   end
   // Operands stay with the taken opcode until the next one is taken
   always @(posedge i_clk)
      if (i_sys_rst)
         o_op_valid <= 1'b0;
      else if (!o_op_valid || i_op_ready)
      begin
         if (o_op_valid)
            o_operands <= pend;
         // Random gaps so that prompt and slow offers both occur
         if (q.size() > 0 && $urandom_range(3) != 0)
         begin
            o_op_valid <= 1'b1;
            {o_opcode, pend} <= q.pop_front();
         end
         else
         begin
            o_op_valid <= 1'b0;
            o_opcode   <= ~o_opcode;
         end
      end
endmodule

// ===== test_cpu_opcode_decode_timing.sv
`timescale 1ns/100ps
module test_cpu_opcode_decode_timing;
   import cdt_pkg::*;
   localparam int         LIMIT = 20000;
   localparam logic [7:0] XOPS [6] = '{8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
   logic             i_clk = 1'b0;
   logic             i_sys_rst = 1'b1;
   logic             carry_wr = 1'b0;
   logic             carry_in = 1'b0;
   logic             ctrl_wr = 1'b0;
   logic [7:0]       ctrl_wdata = 8'h00;
   logic             timer_fast = 1'b0;
   wire logic        op_valid;
   wire logic [7:0]  opcode;
   wire logic [4:0]  opnd;
   logic             op_ready, done, branch, bit_wr, bit_data, carry, inst_tick, timer_tick;
   cdt_class_t       cls;
   logic [1:0]       bytes;
   logic [3:0]       cycles;
   logic [2:0]       stretch, xs;
   int               mismatches = 0, compares = 0, cyc = 0, e = 0, tcnt = 0;
   logic             busy = 1'b0, tvalid = 1'b0, last_fast = 1'b0, xc, xbd, xbr, xbw;
   logic [7:0]       cop, len;

   always #5 i_clk = ~i_clk;

   cdt_fetch_model i_cdt_fetch_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_op_ready(op_ready), .o_op_valid(op_valid), .o_opcode(opcode), .o_operands(opnd));

   cdt_decode i_cdt_decode (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_op_valid(op_valid),
      .i_opcode(opcode), .i_acc_zero(opnd[4]), .i_bit_val(opnd[3]), .i_cmp_ne(opnd[2]),
      .i_cmp_lt(opnd[1]), .i_dec_nz(opnd[0]), .i_carry_wr(carry_wr), .i_carry_in(carry_in),
      .i_clk_ctrl_wr(ctrl_wr), .i_clk_ctrl_wdata(ctrl_wdata), .i_timer_fast(timer_fast),
      .o_op_ready(op_ready), .o_class(cls), .o_bytes(bytes), .o_cycles(cycles),
      .o_done(done), .o_branch(branch), .o_bit_wr(bit_wr), .o_bit_data(bit_data),
      .o_carry_flag(carry), .o_stretch(stretch), .o_inst_tick(inst_tick),
      .o_timer_tick(timer_tick));

   task automatic compare(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // High nibble bytes, low nibble instruction cycles
   function automatic logic [7:0] exp_len(input logic [7:0] op, input logic [2:0] s);
      casez (op)
         8'h90: return 8'h33;
         8'h93, 8'h83, 8'h73: return 8'h13;
         8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: return {4'h1, 4'h2 + {1'b0, s}};
         8'hC0, 8'hD0, 8'hC5, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2,
         8'h92: return 8'h22;
         8'b????0001, 8'h60, 8'h70, 8'b1101_1???: return 8'h23;
         8'h12, 8'h02, 8'h10, 8'hD5, 8'b1011_01??, 8'b1011_1???: return 8'h34;
         default: return 8'h11;
      endcase
   endfunction

   task automatic finish_op();
      xbr = 1'b0;
      xbw = 1'b0;
      casez (cop)
         8'b????0001, 8'h12, 8'h02, 8'h73: xbr = 1'b1;
         8'h10: {xbr, xbw, xbd} = {opnd[3], opnd[3], 1'b0};
         8'h60: xbr = opnd[4];
         8'h70: xbr = !opnd[4];
         8'b1011_01??, 8'b1011_1???: {xbr, xc} = {opnd[2], opnd[1]};
         8'hD5, 8'b1101_1???: xbr = opnd[0];
         8'hC2: {xbw, xbd} = 2'h2;
         8'hD2: {xbw, xbd} = 2'h3;
         8'hB2: {xbw, xbd} = {1'b1, !opnd[3]};
         8'h92: {xbw, xbd} = {1'b1, xc};
         8'hC3: xc = 1'b0;
         8'hD3: xc = 1'b1;
         8'hB3: xc = !xc;
         8'h82: xc = xc & opnd[3];
         8'hB0: xc = xc & !opnd[3];
         8'h72: xc = xc | opnd[3];
         8'hA0: xc = xc | !opnd[3];
         8'hA2: xc = opnd[3];
         default: ;
      endcase
      compare(e, 4 * len[3:0] + 1, "done timing");
      compare({bytes, cycles}, {len[5:4], len[3:0]}, "length");
      compare(branch, xbr, "branch");
      compare({bit_wr, bit_data}, {xbw, xbd}, "bit write");
      compare(carry, xc, "carry");
      if (cop == 8'h00 || cop == 8'hA5)
         compare(cls, CDT_NOP, "no-op class");
      busy = 1'b0;
   endtask

   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         mismatches++;
         close_out();
      end
      else if (i_sys_rst)
      begin
         {busy, tvalid, xc, xbd} = 4'h0;
         xs = STRETCH_RST;
      end
      else
      begin
         tcnt++;
         if (timer_fast !== last_fast)
            tvalid = 1'b0;
         last_fast = timer_fast;
         if (timer_tick)
         begin
            if (tvalid)
               compare(tcnt, timer_fast ? TMR_DIV_FAST : TMR_DIV_SLOW, "timer period");
            tvalid = 1'b1;
            tcnt = 0;
         end
         if (!busy)
            compare({done, branch, bit_wr}, 3'h0, "stray done");
         else
         begin
            e++;
            if (done)
               finish_op();
            else
            begin
               compare(op_ready, 1'b0, "ready while busy");
               compare(inst_tick, (e % 4) == 0, "instruction tick");
               compare(e <= 4 * len[3:0], 1'b1, "done late");
            end
         end
         if (carry_wr)
            xc = carry_in;
         if (ctrl_wr)
            xs = ctrl_wdata[2:0];
         if (op_valid && op_ready)
         begin
            compare(busy, 1'b0, "taken while busy");
            busy = 1'b1;
            e = 0;
            cop = opcode;
            len = exp_len(opcode, xs);
         end
      end
   end

   task automatic drain();
      repeat (3) @(posedge i_clk);
      while (busy || op_valid || i_cdt_fetch_model.q.size() > 0)
         @(posedge i_clk);
      #1;
   endtask

   // Upper control bits are random to show they are ignored
   task automatic setup(input logic c, input logic [7:0] v);
      @(posedge i_clk);
      {carry_wr, carry_in, ctrl_wr, ctrl_wdata} <= {1'b1, c, 1'b1, v};
      @(posedge i_clk);
      {carry_wr, carry_in, ctrl_wr, ctrl_wdata} <= {1'b0, !c, 1'b0, ~v};
      #1;
      compare({carry, stretch}, {c, v[2:0]}, "carry and stretch write");
   endtask

   initial
   begin
      void'($urandom(32'h86949696));
      repeat (10) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      #1;
      compare({op_ready, carry, stretch, cycles}, {1'b1, 1'b0, 3'h1, 4'h0}, "reset");
      compare(cls, CDT_NOP, "reset class");
      $display("Test reset done");
      for (int i = 0; i < 256; i++)
         i_cdt_fetch_model.push(8'(i), 5'($urandom));
      drain();
      $display("Test opcode sweep done");
      for (int s = 7; s >= 0; s--)
      begin
         setup(1'($urandom), (8'($urandom) & 8'hF8) | 8'(s));
         foreach (XOPS[j])
            i_cdt_fetch_model.push(XOPS[j], 5'($urandom));
         drain();
      end
      $display("Test stretch sweep done");
      @(posedge i_clk);
      timer_fast <= 1'b1;
      repeat (80)
         i_cdt_fetch_model.push(8'($urandom), 5'($urandom));
      drain();
      @(posedge i_clk);
      timer_fast <= 1'b0;
      repeat (40) @(posedge i_clk);
      $display("Test random opcodes and timer rates done");
      close_out();
   end
endmodule
